// ---- dcbm_mem_model.sv ----
// Behavioural translation unit and memory port facing the maintenance unit
`timescale 1ns/10ps
module dcbm_mem_model (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic sys_rst,
  // Requests from the unit
  input  wire logic mmu_req,
  input  wire logic wb_req,
  // Behaviour chosen by the bench
  input  wire logic slow,
  input  wire logic deny,
  input  wire logic dstore,
  // Answers
  output logic      mmu_ack,
  output logic      mmu_allow,
  output logic      mmu_direct_store,
  output logic      wb_ack
);
  logic [2:0] cnt_q;
  logic       tog_q;
  logic       busy;
  logic       fire;

  // ------------------------------------------------------------
  // Answer after zero or three wait cycles
  // ------------------------------------------------------------
  assign busy = (mmu_req | wb_req) & ~mmu_ack & ~wb_ack;
  assign fire = busy & (cnt_q >= (slow ? 3'h3 : 3'h0));

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      {cnt_q, tog_q, mmu_ack, wb_ack} <= '0;
    end else begin
      tog_q   <= ~tog_q;
      mmu_ack <= fire & mmu_req;
      wb_ack  <= fire & wb_req;
      cnt_q   <= (busy & ~fire) ? cnt_q + 3'h1 : 3'h0;
    end
  end

  // Qualifiers only hold meaning with the acknowledge; junk otherwise
  assign mmu_allow        = mmu_ack ? ~deny : tog_q;
  assign mmu_direct_store = mmu_ack ? dstore : ~tog_q;
endmodule : dcbm_mem_model

// ---- dcbm_pkg.sv ----
// Constants and types for the data cache block maintenance unit
//
// Notes on behaviour
// - Flush decodes as primary opcode 31, extended opcode 86; bits 6-10, 31 ignored.
// - Invalidate decodes as primary opcode 31, extended opcode 470.
// - Store-block decodes as primary opcode 31, extended opcode 54.
// - Address is base plus index; base field zero means base value zero.
// - Flush writes a modified resident block back to main memory.
// - Flush then invalidates the block here and in every other cache.
// - Flush to a direct-store segment does nothing at all.
// - No operation touches the exception register; single encoding form only.
// - Invalidate drops a resident block without write-back; refetch comes from memory.
// - Invalidate is checked for protection as a store.
// - Store-block writes a modified resident block back to main memory.
// - Store-block is translated and checked as a load.
package dcbm_pkg;

  // --------------------------------------------------------------------
  // Instruction fields (bit 31 is the most significant bit)
  // --------------------------------------------------------------------
  localparam int unsigned PRI_HI   = 31;
  localparam int unsigned PRI_LO   = 26;
  localparam int unsigned XO_HI    = 10;
  localparam int unsigned XO_LO    = 1;
  localparam int unsigned BASE_HI  = 20;
  localparam int unsigned BASE_LO  = 16;
  localparam logic [5:0]  OPC_PRI  = 6'h1F;
  localparam logic [9:0]  XO_FLUSH = 10'h056;
  localparam logic [9:0]  XO_INV   = 10'h1D6;
  localparam logic [9:0]  XO_STORE = 10'h036;
  localparam logic [4:0]  BASE_ZERO = 5'h00;

  // --------------------------------------------------------------------
  // Sizes and reset values
  // --------------------------------------------------------------------
  localparam int unsigned ADDR_W_DEF     = 32;
  localparam int unsigned BLOCK_BYTES_DEF = 32;
  localparam int unsigned LINES_DEF      = 64;
  localparam logic        RST_LOW        = 1'b0;
  localparam logic        RST_READY      = 1'b1;

  // --------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    DCBM_OP_NONE  = 2'b00,
    DCBM_OP_FLUSH = 2'b01,
    DCBM_OP_INV   = 2'b10,
    DCBM_OP_STORE = 2'b11
  } dcbm_op_e;

  typedef enum logic [2:0] {
    DCBM_ST_IDLE   = 3'b000,
    DCBM_ST_CHECK  = 3'b001,
    DCBM_ST_LOOKUP = 3'b010,
    DCBM_ST_WB     = 3'b011,
    DCBM_ST_UPDATE = 3'b100,
    DCBM_ST_DONE   = 3'b101
  } dcbm_state_e;

endpackage : dcbm_pkg

// ---- dcbm_top.sv ----
// Data cache block maintenance unit: decode, checks, tag state, write-back
`timescale 1ns/10ps
module dcbm_top #(
  parameter int unsigned ADDR_W      = dcbm_pkg::ADDR_W_DEF,
  parameter int unsigned BLOCK_BYTES = dcbm_pkg::BLOCK_BYTES_DEF,
  parameter int unsigned LINES       = dcbm_pkg::LINES_DEF
) (
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  // Issue from the pipeline
  input  wire logic              op_valid,
  input  wire logic [31:0]       op_instr,
  input  wire logic [ADDR_W-1:0] op_base_val,
  input  wire logic [ADDR_W-1:0] op_index_val,
  output logic                   op_ready,
  // Completion
  output logic                   done,
  output logic                   done_illegal,
  output logic                   done_fault,
  // Translation and protection
  output logic                   mmu_req,
  output logic [ADDR_W-1:0]      mmu_ea,
  output logic                   mmu_is_store,
  input  wire logic              mmu_ack,
  input  wire logic              mmu_allow,
  input  wire logic              mmu_direct_store,
  // Block write-back to memory
  output logic                   wb_req,
  output logic [ADDR_W-1:0]      wb_addr,
  input  wire logic              wb_ack,
  // Invalidate broadcast to other caches
  output logic                   snoop_inv,
  output logic [ADDR_W-1:0]      snoop_addr,
  // Line fill and store-hit marking from the cache
  input  wire logic              fill_valid,
  input  wire logic [ADDR_W-1:0] fill_addr,
  input  wire logic              fill_modified
);
  import dcbm_pkg::*;

  localparam int unsigned OFF_W = $clog2(BLOCK_BYTES);
  localparam int unsigned IDX_W = $clog2(LINES);
  localparam int unsigned TAG_W = ADDR_W - OFF_W - IDX_W;

  // Refuse geometries the index and tag split cannot serve
  if ((BLOCK_BYTES < 2) || ((1 << OFF_W) != BLOCK_BYTES) ||
      (LINES < 2) || ((1 << IDX_W) != LINES) || (ADDR_W <= OFF_W + IDX_W)) begin : g_bad_geom
    $error("dcbm_top: unsupported geometry");
  end

  // --------------------------------------------------------------------
  // Decode and address
  // --------------------------------------------------------------------
  wire logic              pri_ok    = (op_instr[PRI_HI:PRI_LO] == OPC_PRI);
  wire logic [9:0]        xo        = op_instr[XO_HI:XO_LO];
  wire logic              is_flush  = pri_ok && (xo == XO_FLUSH);
  wire logic              is_inv    = pri_ok && (xo == XO_INV);
  wire logic              is_store  = pri_ok && (xo == XO_STORE);
  wire dcbm_op_e          dec_op    = is_flush ? DCBM_OP_FLUSH :
                                      is_inv   ? DCBM_OP_INV   :
                                      is_store ? DCBM_OP_STORE : DCBM_OP_NONE;
  wire logic              base_zero = (op_instr[BASE_HI:BASE_LO] == BASE_ZERO);
  wire logic [ADDR_W-1:0] base_eff  = base_zero ? '0 : op_base_val;
  wire logic [ADDR_W-1:0] ea_calc   = base_eff + op_index_val;
  wire logic              take      = op_valid && op_ready;

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  dcbm_state_e       state_q;
  dcbm_state_e       state_d;
  dcbm_op_e          op_q;
  logic              hit_q;
  logic              mod_q;
  logic [LINES-1:0]  valid_q;
  logic [LINES-1:0]  dirty_q;
  logic [TAG_W-1:0]  tag_q [LINES];

  wire logic [IDX_W-1:0] cur_idx  = mmu_ea[OFF_W +: IDX_W];
  wire logic [TAG_W-1:0] cur_tag  = mmu_ea[ADDR_W-1 -: TAG_W];
  wire logic             look_hit = valid_q[cur_idx] && (tag_q[cur_idx] == cur_tag);
  wire logic             look_mod = look_hit && dirty_q[cur_idx];
  wire logic             need_wb  = look_mod && (op_q != DCBM_OP_INV);
  wire logic             skip_op  = (op_q == DCBM_OP_FLUSH) && mmu_direct_store;
  wire logic             chk_end  = (state_q == DCBM_ST_CHECK) && mmu_ack;
  wire logic             chk_bad  = chk_end && (skip_op || !mmu_allow);
  wire logic             upd      = (state_q == DCBM_ST_UPDATE);
  wire logic [IDX_W-1:0] fill_idx = fill_addr[OFF_W +: IDX_W];
  wire logic [TAG_W-1:0] fill_tag = fill_addr[ADDR_W-1 -: TAG_W];
  wire logic             upd_inv  = upd && hit_q && (op_q != DCBM_OP_STORE);
  wire logic             upd_cln  = upd && hit_q && mod_q && (op_q == DCBM_OP_STORE);

  // --------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      DCBM_ST_IDLE:   if (take) begin
        state_d = (dec_op == DCBM_OP_NONE) ? DCBM_ST_DONE : DCBM_ST_CHECK;
      end
      DCBM_ST_CHECK:  if (mmu_ack) begin
        state_d = chk_bad ? DCBM_ST_DONE : DCBM_ST_LOOKUP;
      end
      DCBM_ST_LOOKUP: state_d = need_wb ? DCBM_ST_WB : DCBM_ST_UPDATE;
      DCBM_ST_WB:     if (wb_ack) begin
        state_d = DCBM_ST_UPDATE;
      end
      DCBM_ST_UPDATE: state_d = DCBM_ST_DONE;
      DCBM_ST_DONE:   state_d = DCBM_ST_IDLE;
      default:        state_d = DCBM_ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= DCBM_ST_IDLE;
      op_q    <= DCBM_OP_NONE;
      hit_q   <= RST_LOW;
      mod_q   <= RST_LOW;
    end else begin
      state_q <= state_d;
      if (take) begin
        op_q <= dec_op;
      end
      if (state_q == DCBM_ST_LOOKUP) begin
        hit_q <= look_hit;
        mod_q <= look_mod;
      end
    end
  end

  // --------------------------------------------------------------------
  // Translation request
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      mmu_req      <= RST_LOW;
      mmu_ea       <= '0;
      mmu_is_store <= RST_LOW;
    end else begin
      if (take && (dec_op != DCBM_OP_NONE)) begin
        mmu_req      <= 1'b1;
        mmu_ea       <= ea_calc;
        mmu_is_store <= (dec_op == DCBM_OP_INV);
      end else if (chk_end) begin
        mmu_req <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Write-back and broadcast
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wb_req     <= RST_LOW;
      wb_addr    <= '0;
      snoop_inv  <= RST_LOW;
      snoop_addr <= '0;
    end else begin
      if ((state_q == DCBM_ST_LOOKUP) && need_wb) begin
        wb_req  <= 1'b1;
        wb_addr <= {mmu_ea[ADDR_W-1:OFF_W], {OFF_W{1'b0}}};
      end else if (wb_ack) begin
        wb_req <= 1'b0;
      end
      snoop_inv <= upd && (op_q == DCBM_OP_FLUSH);
      if (upd) begin
        snoop_addr <= {mmu_ea[ADDR_W-1:OFF_W], {OFF_W{1'b0}}};
      end
    end
  end

  // --------------------------------------------------------------------
  // Handshake and completion
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk or posedge sys_rst) begin
    if (sys_rst) begin
      op_ready     <= RST_READY;
      done         <= RST_LOW;
      done_illegal <= RST_LOW;
      done_fault   <= RST_LOW;
    end else begin
      op_ready     <= (state_d == DCBM_ST_IDLE);
      done         <= (state_d == DCBM_ST_DONE);
      done_illegal <= (state_d == DCBM_ST_DONE) && take && (dec_op == DCBM_OP_NONE);
      done_fault   <= chk_bad && !skip_op;
    end
  end

  // --------------------------------------------------------------------
  // Line state, one entry per line
  // --------------------------------------------------------------------
  for (genvar i = 0; i < LINES; i++) begin : g_line
    wire logic hit_upd = (cur_idx == IDX_W'(i));
    wire logic hit_fil = fill_valid && (fill_idx == IDX_W'(i));
    always_ff @(posedge ref_clk or posedge sys_rst) begin
      if (sys_rst) begin
        valid_q[i] <= RST_LOW;
        dirty_q[i] <= RST_LOW;
        tag_q[i]   <= '0;
      end else if (hit_upd && upd_inv) begin
        valid_q[i] <= 1'b0;
        dirty_q[i] <= 1'b0;
      end else if (hit_upd && upd_cln) begin
        dirty_q[i] <= 1'b0;
      end else if (hit_fil) begin
        valid_q[i] <= 1'b1;
        dirty_q[i] <= fill_modified;
        tag_q[i]   <= fill_tag;
      end
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  property p_dec_flush;
    @(posedge ref_clk) disable iff (sys_rst)
      (take && (op_instr[PRI_HI:PRI_LO] == 6'h1F) && (op_instr[10:1] == 10'h056))
        |=> (op_q == DCBM_OP_FLUSH) && mmu_req;
  endproperty
  a_dec_flush: assert property (p_dec_flush) else $error("flush not decoded");

  property p_dec_inv;
    @(posedge ref_clk) disable iff (sys_rst)
      (take && (op_instr[31:26] == 6'h1F) && (op_instr[10:1] == 10'h1D6))
        |=> (op_q == DCBM_OP_INV) && mmu_is_store;
  endproperty
  a_dec_inv: assert property (p_dec_inv) else $error("invalidate not decoded");

  property p_dec_store;
    @(posedge ref_clk) disable iff (sys_rst)
      (take && (op_instr[31:26] == 6'h1F) && (op_instr[10:1] == 10'h036))
        |=> (op_q == DCBM_OP_STORE) && !mmu_is_store;
  endproperty
  a_dec_store: assert property (p_dec_store) else $error("store-block not decoded");

  property p_ea;
    @(posedge ref_clk) disable iff (sys_rst)
      (take && (dec_op != DCBM_OP_NONE)) |=> (mmu_ea ==
        ($past(op_instr[20:16]) == 5'h00 ? $past(op_index_val)
          : $past(op_base_val) + $past(op_index_val)));
  endproperty
  a_ea: assert property (p_ea) else $error("effective address wrong");

  property p_wb_mod;
    @(posedge ref_clk) disable iff (sys_rst)
      ((state_q == DCBM_ST_LOOKUP) && look_mod && (op_q != DCBM_OP_INV))
        |=> wb_req ##0 (wb_addr[ADDR_W-1:OFF_W] == mmu_ea[ADDR_W-1:OFF_W]);
  endproperty
  a_wb_mod: assert property (p_wb_mod) else $error("modified block not written");

  property p_flush_inv;
    @(posedge ref_clk) disable iff (sys_rst)
      (upd && (op_q == DCBM_OP_FLUSH))
        |=> snoop_inv && done
            && !(valid_q[$past(cur_idx)] && (tag_q[$past(cur_idx)] == $past(cur_tag)))
            ##1 op_ready;
  endproperty
  a_flush_inv: assert property (p_flush_inv) else $error("flush left block valid");

  property p_inv_drop;
    @(posedge ref_clk) disable iff (sys_rst)
      (upd && hit_q && (op_q == DCBM_OP_INV))
        |=> !valid_q[$past(cur_idx)] && !snoop_inv && !wb_req && done;
  endproperty
  a_inv_drop: assert property (p_inv_drop) else $error("invalidate kept block");

  property p_fault_quiet;
    @(posedge ref_clk) disable iff (sys_rst)
      (chk_end && !mmu_allow && !skip_op)
        |=> done && done_fault && !wb_req && !snoop_inv;
  endproperty
  a_fault_quiet: assert property (p_fault_quiet) else $error("refused access acted");

  property p_illegal;
    @(posedge ref_clk) disable iff (sys_rst)
      (take && (op_instr[31:26] != 6'h1F))
        |=> done && done_illegal && !mmu_req;
  endproperty
  a_illegal: assert property (p_illegal) else $error("foreign word acted");

  property p_ds_noop;
    @(posedge ref_clk) disable iff (sys_rst)
      (chk_end && (op_q == DCBM_OP_FLUSH) && mmu_direct_store)
        |=> (!wb_req && !snoop_inv && done && !done_fault) [*1] ##1 op_ready;
  endproperty
  a_ds_noop: assert property (p_ds_noop) else $error("direct-store flush acted");

  property p_inv_nowb;
    @(posedge ref_clk) disable iff (sys_rst)
      (state_q == DCBM_ST_LOOKUP) && (op_q == DCBM_OP_INV) |=> !wb_req [*2];
  endproperty
  a_inv_nowb: assert property (p_inv_nowb) else $error("invalidate wrote back");

  property p_store_keep;
    @(posedge ref_clk) disable iff (sys_rst)
      (upd_cln) |=> valid_q[$past(cur_idx)] && !dirty_q[$past(cur_idx)];
  endproperty
  a_store_keep: assert property (p_store_keep) else $error("store-block lost block");

  property p_prot_kind;
    @(posedge ref_clk) disable iff (sys_rst)
      mmu_req |-> (mmu_is_store == (op_q == DCBM_OP_INV));
  endproperty
  a_prot_kind: assert property (p_prot_kind) else $error("wrong protection kind");

endmodule : dcbm_top

// ---- tb.sv ----
// Self-checking testbench for the data cache block maintenance unit
`timescale 1ns/10ps
module tb;
  import dcbm_pkg::*;
  logic        ref_clk, sys_rst, op_valid, op_ready, done, done_illegal, done_fault;
  logic [31:0] op_instr, op_base_val, op_index_val, mmu_ea, wb_addr, snoop_addr, fill_addr;
  logic        mmu_req, mmu_is_store, mmu_ack, mmu_allow, mmu_direct_store, wb_req, wb_ack;
  logic        snoop_inv, fill_valid, fill_modified, slow, deny, dstore, d;
  logic [31:0] rng, a, b;
  logic [9:0]  xo;
  int          errors, n_compared, op;

  dcbm_top dcbm_top_inst (.ref_clk(ref_clk), .sys_rst(sys_rst), .op_valid(op_valid),
    .op_instr(op_instr), .op_base_val(op_base_val), .op_index_val(op_index_val),
    .op_ready(op_ready), .done(done), .done_illegal(done_illegal), .done_fault(done_fault),
    .mmu_req(mmu_req), .mmu_ea(mmu_ea), .mmu_is_store(mmu_is_store), .mmu_ack(mmu_ack),
    .mmu_allow(mmu_allow), .mmu_direct_store(mmu_direct_store), .wb_req(wb_req),
    .wb_addr(wb_addr), .wb_ack(wb_ack), .snoop_inv(snoop_inv), .snoop_addr(snoop_addr),
    .fill_valid(fill_valid), .fill_addr(fill_addr), .fill_modified(fill_modified));

  dcbm_mem_model dcbm_mem_model_inst (.ref_clk(ref_clk), .sys_rst(sys_rst),
    .mmu_req(mmu_req), .wb_req(wb_req), .slow(slow), .deny(deny), .dstore(dstore),
    .mmu_ack(mmu_ack), .mmu_allow(mmu_allow), .mmu_direct_store(mmu_direct_store),
    .wb_ack(wb_ack));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction : xs

  // Unused fields filled with junk
  function automatic logic [31:0] mk(input logic [9:0] x, input logic [4:0] bf,
                                     input logic [31:0] j);
    return {OPC_PRI, j[4:0], bf, 5'h03, x, j[5]};
  endfunction : mk

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize

  task automatic fill(input logic [31:0] fa, input logic m);
    @(posedge ref_clk);
    {fill_valid, fill_addr, fill_modified} <= {1'b1, fa, m};
    @(posedge ref_clk);
    fill_valid <= 1'b0;
  endtask : fill

  task automatic run_op(input logic [31:0] w, bv, iv, ea, input logic ew, es, ef, eil, eis);
    logic        sw, ss, sf, sis;
    logic [31:0] sea, swa, ssa;
    int          n;
    {sw, ss, sf, sis, sea} = {3'b000, eis, ea};
    {swa, ssa} = {2{ea & 32'hFFFF_FFE0}};
    n = 0;
    while (op_ready !== 1'b1 && n < 100) begin
      @(negedge ref_clk);
      n++;
    end
    @(posedge ref_clk);
    {op_valid, op_instr, op_base_val, op_index_val} <= {1'b1, w, bv, iv};
    @(posedge ref_clk);
    op_valid <= 1'b0;
    for (n = 0; n < 200; n++) begin
      @(negedge ref_clk);
      if (mmu_req === 1'b1) {sis, sea} = {mmu_is_store, mmu_ea};
      if (wb_req === 1'b1) {sw, swa} = {1'b1, wb_addr};
      if (snoop_inv === 1'b1) {ss, ssa} = {1'b1, snoop_addr};
      if (done_fault === 1'b1) sf = 1'b1;
      if (done === 1'b1) break;
    end
    chk("done", 32'(done), 32'h1);
    chk("done_illegal", 32'(done_illegal), 32'(eil));
    chk("done_fault", 32'(sf), 32'(ef));
    chk("mmu_is_store", 32'(sis), 32'(eis));
    chk("mmu_ea", sea, ea);
    chk("wb_req", 32'(sw), 32'(ew));
    chk("wb_addr", swa, ea & 32'hFFFF_FFE0);
    chk("snoop_inv", 32'(ss), 32'(es));
    chk("snoop_addr", ssa, ea & 32'hFFFF_FFE0);
  endtask : run_op

  // ------------------------------------------------------------
  // Clock, watchdog and main sequence
  // ------------------------------------------------------------
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  initial begin
    #(50 * 40000);
    errors++;
    summarize();
  end

  initial begin
    {sys_rst, op_valid, op_instr, op_base_val, op_index_val} = {2'b10, 96'h0};
    {fill_valid, fill_addr, fill_modified, slow, deny, dstore} = '0;
    {errors, n_compared, rng} = {32'd0, 32'd0, 32'd95054};
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    a = xs();
    b = xs();
    // Dirty flush, then the line is gone
    fill(a, 1'b1);
    run_op(mk(XO_FLUSH, 5'h04, xs()), b, a - b, a, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
    run_op(mk(XO_STORE, 5'h04, xs()), b, a - b, a, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    // Base field zero ignores the base value; second store finds it clean
    fill(a, 1'b1);
    slow = 1'b1;
    run_op(mk(XO_STORE, BASE_ZERO, xs()), xs(), a, a, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    run_op(mk(XO_STORE, BASE_ZERO, xs()), xs(), a, a, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    run_op(mk(XO_FLUSH, 5'h1F, xs()), b, a - b, a, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    // Invalidate drops dirty data
    fill(a, 1'b1);
    run_op(mk(XO_INV, 5'h01, xs()), b, a - b, a, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
    run_op(mk(XO_FLUSH, 5'h01, xs()), b, a - b, a, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
    // Direct-store flush leaves the dirty line alone
    fill(a, 1'b1);
    dstore = 1'b1;
    run_op(mk(XO_FLUSH, 5'h02, xs()), b, a - b, a, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
    dstore = 1'b0;
    run_op(mk(XO_STORE, 5'h02, xs()), b, a - b, a, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
    // Protection refused: nothing happens
    fill(a, 1'b1);
    deny = 1'b1;
    run_op(mk(XO_FLUSH, 5'h02, xs()), b, a - b, a, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    run_op(mk(XO_INV, 5'h02, xs()), b, a - b, a, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
    deny = 1'b0;
    // Neighbouring codes are not maintenance operations
    run_op(mk(10'h116, 5'h02, xs()), b, a - b, a, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    run_op(mk(10'h057, 5'h02, xs()), b, a - b, a, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    run_op({6'h13, 10'h0, 5'h02, XO_FLUSH, 1'b0}, b, a - b, a, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
    // Random mix of operations, line state and answer speed
    for (int i = 0; i < 80; i++) begin
      {slow, d} = 2'(xs());
      op = int'(xs() % 3);
      xo = (op == 0) ? XO_FLUSH : (op == 1) ? XO_INV : XO_STORE;
      a = xs();
      b = xs();
      fill(a, d);
      run_op(mk(xo, 5'h07, xs()), b, a - b, a, d & (op != 1), op == 0, 1'b0, 1'b0, op == 1);
    end
    summarize();
  end
endmodule : tb
